// File: src/ptb_pkg.sv
// Package with constants and types for the PWM time base.
package ptb_pkg;

  // ****************************************************************
  // Register map (byte addresses on APB).
  // ****************************************************************
  localparam logic [7:0] PTB_ADDR_CONTROL = 8'h00;
  localparam logic [7:0] PTB_ADDR_COUNT = 8'h04;
  localparam logic [7:0] PTB_ADDR_PERIOD = 8'h08;
  localparam logic [7:0] PTB_ADDR_ACTIVE = 8'h0C;

  // ****************************************************************
  // Control and count register fields.
  // ****************************************************************
  localparam int PTB_EN_BIT = 15;
  localparam int PTB_OPS_LSB = 4;
  localparam int PTB_CKPS_LSB = 2;
  localparam int PTB_MOD_LSB = 0;
  localparam int PTB_DIR_BIT = 15;

  // ****************************************************************
  // Reset values and fixed figures.
  // ****************************************************************
  localparam logic [14:0] PTB_COUNT_RST = 15'h0000;
  localparam logic [14:0] PTB_PERIOD_RST = 15'h0000;
  localparam logic [14:0] PTB_ZERO = 15'h0000;
  localparam logic [1:0] PTB_QUARTER_MAX = 2'h3;

  // ****************************************************************
  // Counting modes and prescale choices.
  // ****************************************************************
  typedef enum logic [1:0] {
    PTB_FREE = 2'h0,
    PTB_SINGLE = 2'h1,
    PTB_UPDOWN = 2'h2,
    PTB_DOUBLE = 2'h3
  } ptb_mode_t;

  localparam logic [5:0] PTB_PRE_1 = 6'h00;
  localparam logic [5:0] PTB_PRE_4 = 6'h03;
  localparam logic [5:0] PTB_PRE_16 = 6'h0F;
  localparam logic [5:0] PTB_PRE_64 = 6'h3F;

endpackage : ptb_pkg

// File: src/ptb_time_base.sv
// PWM time base with prescaler, postscaler and APB registers.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RULE_01 - 15-bit counter, prescaled input, postscaled match.
// RULE_02 - Count bit 15 reads direction, one down.
// RULE_03 - Enable starts; clearing keeps count value.
// RULE_04 - Match: next tick resets or reverses.
// RULE_05 - Zero period: stopped, no events.
// RULE_06 - Zero active period blocks reload until disabled.
// RULE_07 - Two-bit mode field selects four modes.
// RULE_08 - Free running: up, reset, continue.
// RULE_09 - Free running: event per reset, postscaled.
// RULE_10 - Single shot: reset at match, clear enable.
// RULE_11 - Single shot: one event, no postscale.
// RULE_12 - Up/down: reverse at match, direction set.
// RULE_13 - Up/down: event at zero, postscaled.
// RULE_14 - Double update: events zero and match.
// RULE_15 - Software avoids period of one.
// RULE_16 - Input clock is ref/4 then prescaled.
// RULE_17 - Prescaler cleared by count/control writes, reset.
// RULE_18 - Four-bit postscaler, ratios one to sixteen.
// RULE_19 - Postscaler cleared by count/control writes, reset.
// RULE_20 - Period double buffered, loaded at cycle boundaries.
// RULE_21 - Postscaled event is one-cycle pulse.
module ptb_time_base
  import ptb_pkg::*;
#(
  parameter int CW = 15
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Time base outputs to comparators and interrupt controller.
  output logic [CW-1:0] COUNT_VALUE,
  output logic COUNT_DIRECTION,
  output logic PERIOD_MATCH,
  output logic TIME_BASE_EVENT
);

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  logic wr_en;
  logic wr_ctl;
  logic wr_cnt;
  logic wr_per;
  logic mapped;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign wr_ctl = wr_en && (PADDR == PTB_ADDR_CONTROL);
  assign wr_cnt = wr_en && (PADDR == PTB_ADDR_COUNT);
  assign wr_per = wr_en && (PADDR == PTB_ADDR_PERIOD);
  assign mapped = (PADDR == PTB_ADDR_CONTROL) ||
                  (PADDR == PTB_ADDR_COUNT) ||
                  (PADDR == PTB_ADDR_PERIOD) ||
                  (PADDR == PTB_ADDR_ACTIVE);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // ****************************************************************
  // State.
  // ****************************************************************
  logic time_base_enable_q;
  logic [3:0] postscale_select_q;
  logic [1:0] prescale_select_q;
  ptb_mode_t counting_mode_select_q;
  logic [CW-1:0] time_base_count_q;
  logic count_direction_status_q;
  logic [CW-1:0] period_buf_q;
  logic [CW-1:0] time_base_period_q;
  logic [1:0] quarter_q;
  logic [5:0] pre_q;
  logic [3:0] post_q;
  logic match_q;
  logic event_q;

  // ****************************************************************
  // Tick generation.
  // ****************************************************************
  logic [5:0] pre_lim;
  logic tick;
  logic per_zero;
  logic at_match;
  logic at_zero;
  always_comb begin
    case (prescale_select_q) // RULE_16
      2'h0: pre_lim = PTB_PRE_1;
      2'h1: pre_lim = PTB_PRE_4;
      2'h2: pre_lim = PTB_PRE_16;
      default: pre_lim = PTB_PRE_64;
    endcase
  end
  assign per_zero = (time_base_period_q == PTB_ZERO);
  // The count advances only on a prescaled quarter-rate tick.
  assign tick = time_base_enable_q && !per_zero && // RULE_05
                (quarter_q == PTB_QUARTER_MAX) && (pre_q == pre_lim); // RULE_16
  assign at_match = (time_base_count_q == time_base_period_q); // RULE_04
  assign at_zero = (time_base_count_q == PTB_ZERO);

  // Quarter divider models the oscillator divided by four.
  always_ff @(posedge REF_CLK) begin
    if (RST || wr_cnt || wr_ctl) begin
      quarter_q <= 2'h0;
    end else begin
      quarter_q <= quarter_q + 2'h1; // RULE_16
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST || wr_cnt || wr_ctl) begin
      pre_q <= 6'h00; // RULE_17
    end else if (time_base_enable_q && quarter_q == PTB_QUARTER_MAX) begin
      pre_q <= (pre_q == pre_lim) ? 6'h00 : pre_q + 6'h01;
    end
  end

  // ****************************************************************
  // Counter and direction.
  // ****************************************************************
  logic raw_event;
  logic post_mode;
  logic rev_up;
  logic rev_down;
  assign post_mode = (counting_mode_select_q == PTB_FREE) ||
                     (counting_mode_select_q == PTB_UPDOWN);
  assign rev_down = tick && count_direction_status_q == 1'b0 && at_match &&
                    counting_mode_select_q[1];
  assign rev_up = tick && count_direction_status_q && at_zero &&
                  counting_mode_select_q[1];

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      time_base_count_q <= PTB_COUNT_RST;
      count_direction_status_q <= 1'b0;
    end else if (wr_cnt) begin
      time_base_count_q <= PWDATA[CW-1:0];
    end else if (tick) begin
      if (!counting_mode_select_q[1]) begin
        count_direction_status_q <= 1'b0;
        if (at_match) begin
          time_base_count_q <= PTB_ZERO; // RULE_08 RULE_10
        end else begin
          time_base_count_q <= time_base_count_q + 1'b1;
        end
      end else if (!count_direction_status_q) begin
        if (at_match) begin
          count_direction_status_q <= 1'b1; // RULE_12
          time_base_count_q <= time_base_count_q - 1'b1;
        end else begin
          time_base_count_q <= time_base_count_q + 1'b1;
        end
      end else begin
        if (at_zero) begin
          count_direction_status_q <= 1'b0;
          time_base_count_q <= time_base_count_q + 1'b1;
        end else begin
          time_base_count_q <= time_base_count_q - 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Control register.
  // ****************************************************************
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      time_base_enable_q <= 1'b0;
      postscale_select_q <= 4'h0;
      prescale_select_q <= 2'h0;
      counting_mode_select_q <= PTB_FREE;
    end else if (wr_ctl) begin
      time_base_enable_q <= PWDATA[PTB_EN_BIT]; // RULE_03
      postscale_select_q <= PWDATA[PTB_OPS_LSB +: 4]; // RULE_18
      prescale_select_q <= PWDATA[PTB_CKPS_LSB +: 2];
      counting_mode_select_q <= ptb_mode_t'(PWDATA[PTB_MOD_LSB +: 2]); // RULE_07
    end else if (tick && at_match && counting_mode_select_q == PTB_SINGLE) begin
      time_base_enable_q <= 1'b0; // RULE_10
    end
  end

  // ****************************************************************
  // Period double buffer.
  // ****************************************************************
  logic load_per;
  assign load_per = !time_base_enable_q || // RULE_20
                    (!per_zero && tick && // RULE_06
                     ((!counting_mode_select_q[1] && at_match) || rev_up));
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      period_buf_q <= PTB_PERIOD_RST;
    end else if (wr_per) begin
      period_buf_q <= PWDATA[CW-1:0];
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      time_base_period_q <= PTB_PERIOD_RST;
    end else if (load_per) begin
      time_base_period_q <= period_buf_q; // RULE_20
    end
  end

  // ****************************************************************
  // Events and postscaler.
  // ****************************************************************
  always_comb begin
    case (counting_mode_select_q)
      PTB_FREE: raw_event = tick && at_match; // RULE_09
      PTB_SINGLE: raw_event = tick && at_match; // RULE_11
      PTB_UPDOWN: raw_event = rev_up; // RULE_13
      PTB_DOUBLE: raw_event = rev_up || rev_down; // RULE_14
      default: raw_event = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST || wr_cnt || wr_ctl) begin
      post_q <= 4'h0; // RULE_19
    end else if (raw_event && post_mode) begin
      post_q <= (post_q == postscale_select_q) ? 4'h0 : post_q + 4'h1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      event_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      event_q <= raw_event && (!post_mode || // RULE_21
                 post_q == postscale_select_q); // RULE_18
      match_q <= tick && at_match; // RULE_01
    end
  end

  // ****************************************************************
  // Outputs and read data.
  // ****************************************************************
  assign COUNT_VALUE = time_base_count_q;
  assign COUNT_DIRECTION = count_direction_status_q;
  assign PERIOD_MATCH = match_q;
  assign TIME_BASE_EVENT = event_q;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        PTB_ADDR_CONTROL: PRDATA <= {16'h0000, time_base_enable_q, 7'h00,
          postscale_select_q, prescale_select_q, counting_mode_select_q};
        PTB_ADDR_COUNT: PRDATA <= {16'h0000, count_direction_status_q, // RULE_02
          time_base_count_q};
        PTB_ADDR_PERIOD: PRDATA <= {17'h0_0000, period_buf_q};
        PTB_ADDR_ACTIVE: PRDATA <= {17'h0_0000, time_base_period_q};
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
  end

endmodule // ptb_time_base

`default_nettype wire

// File: sim/ptb_event_sink.sv
// Model of the interrupt side that tallies time base events.
`timescale 1ns/100ps
`default_nettype none
module ptb_event_sink (
  // Clock, reset, event in and tally out.
  input wire logic clk,
  input wire logic rst,
  input wire logic evt,
  output logic [15:0] tally_q
);
  always_ff @(posedge clk) begin
    tally_q <= rst ? 16'h0000 : tally_q + {15'h0000, evt};
  end
endmodule // ptb_event_sink
`default_nettype wire

// File: sim/ptb_time_base_chk.sv
// Port checker of the PWM time base.
`timescale 1ns/100ps
`default_nettype none
module ptb_time_base_chk
  import ptb_pkg::*;
#(
  parameter int CW = 15
) (
  // Clock, reset and APB request.
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  // Time base outputs.
  input wire logic [CW-1:0] COUNT_VALUE,
  input wire logic COUNT_DIRECTION,
  input wire logic PERIOD_MATCH,
  input wire logic TIME_BASE_EVENT
);
  wire logic wr = PSEL && PENABLE && PWRITE;
  logic [1:0] mode_q;
  always_ff @(posedge REF_CLK) begin
    if (RST || (wr && PADDR == PTB_ADDR_CONTROL)) begin
      mode_q <= RST ? 2'h0 : PWDATA[1:0];
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  property p_evt; TIME_BASE_EVENT |=> !TIME_BASE_EVENT; endproperty
  a_evt: assert property (p_evt) else $error("event too wide");
  property p_match; PERIOD_MATCH |=> !PERIOD_MATCH; endproperty
  a_match: assert property (p_match) else $error("match too wide");
  property p_tick; disable iff (RST || wr)
    $changed(COUNT_VALUE) |=> $stable(COUNT_VALUE)[*3]; endproperty
  a_tick: assert property (p_tick) else $error("tick too soon");
  property p_step; $changed(COUNT_VALUE) && !$past(wr) |-> COUNT_VALUE == 0
    || COUNT_VALUE == $past(COUNT_VALUE) + 1'b1
    || COUNT_VALUE == $past(COUNT_VALUE) - 1'b1; endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_stop; wr && PADDR == PTB_ADDR_CONTROL && !PWDATA[PTB_EN_BIT]
    |=> ##1 $stable(COUNT_VALUE)[*7]; endproperty
  a_stop: assert property (p_stop) else $error("count moved");
  property p_dir; $rose(COUNT_DIRECTION) |-> mode_q[1]; endproperty
  a_dir: assert property (p_dir) else $error("down in edge mode");
  property p_zero; TIME_BASE_EVENT && !mode_q[1]
    |-> COUNT_VALUE == 0 && !COUNT_DIRECTION; endproperty
  a_zero: assert property (p_zero) else $error("event off zero");
  property p_single; TIME_BASE_EVENT && mode_q == PTB_SINGLE
    |=> $stable(COUNT_VALUE)[*8]; endproperty
  a_single: assert property (p_single) else $error("shot ran on");
endmodule // ptb_time_base_chk
bind ptb_time_base ptb_time_base_chk #(.CW(CW)) ptb_time_base_chk_inst (
  .REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .COUNT_VALUE(COUNT_VALUE), .COUNT_DIRECTION(COUNT_DIRECTION),
  .PERIOD_MATCH(PERIOD_MATCH), .TIME_BASE_EVENT(TIME_BASE_EVENT));
`default_nettype wire

// File: sim/ptb_time_base_tb_top.sv
// Self-checking testbench of the PWM time base.
`timescale 1ns/100ps
`default_nettype none
module ptb_time_base_tb_top
  import ptb_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, r0;
  logic pready, pslverr, dir, match, evt, err;
  logic [14:0] cnt;
  logic [15:0] tally;
  int errors = 0, n_checks = 0, cyc = 0, n = 0;
  always #5 clk = ~clk;
  ptb_time_base #(.CW(15)) ptb_time_base_inst (.REF_CLK(clk), .RST(rst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .COUNT_VALUE(cnt), .COUNT_DIRECTION(dir), .PERIOD_MATCH(match),
    .TIME_BASE_EVENT(evt));
  ptb_event_sink ptb_event_sink_inst (.clk(clk), .rst(rst), .evt(evt),
    .tally_q(tally));
  task end_sim;
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_evt;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (evt !== 1'b1 && n < 1000);
  endtask
  task t_zero;
    apb(8'h10, 1'b0, 32'h0000_0000);
    chk(err === 1'b1 && rd === 32'h0000_0000, "unmapped");
    apb(PTB_ADDR_CONTROL, 1'b1, 32'h0000_8000);
    repeat (40) @(posedge clk);
    chk(cnt === 15'h0000 && tally === 16'h0000, "zero period");
    apb(PTB_ADDR_PERIOD, 1'b1, 32'h0000_0002);
    apb(PTB_ADDR_ACTIVE, 1'b0, 32'h0000_0000);
    chk(rd === 32'h0000_0000, "period taken");
    apb(PTB_ADDR_CONTROL, 1'b1, 32'h0000_0000);
    apb(PTB_ADDR_ACTIVE, 1'b0, 32'h0000_0000);
    chk(rd === 32'h0000_0002, "period kept");
  endtask
  task t_modes;
    logic [15:0] ctl [6] = '{16'h8010, 16'h8004, 16'h8008, 16'h800C,
      16'h8013, 16'h8012};
    int sp [6] = '{24, 48, 192, 768, 8, 32};
    for (int i = 0; i < 6; i++) begin
      apb(PTB_ADDR_CONTROL, 1'b1, {16'h0000, ctl[i]});
      repeat (2) wait_evt();
      chk(n == sp[i], "spacing");
      if (i < 4) begin
        chk(match === 1'b1, "match");
      end
    end
    apb(PTB_ADDR_CONTROL, 1'b1, 32'h0000_0000);
    apb(PTB_ADDR_COUNT, 1'b0, 32'h0000_0000);
    r0 = rd;
    repeat (20) @(posedge clk);
    apb(PTB_ADDR_COUNT, 1'b0, 32'h0000_0000);
    chk(rd === r0 && r0[15] === 1'b0, "stop");
  endtask
  task t_single;
    apb(PTB_ADDR_COUNT, 1'b1, 32'h0000_0000);
    apb(PTB_ADDR_CONTROL, 1'b1, 32'h0000_8011);
    wait_evt();
    chk(n < 1000, "no shot");
    apb(PTB_ADDR_CONTROL, 1'b0, 32'h0000_0000);
    chk(rd[15] === 1'b0, "enable kept");
    apb(PTB_ADDR_COUNT, 1'b0, 32'h0000_0000);
    chk(rd[14:0] === 15'h0000, "count kept");
    wait_evt();
    chk(n == 1000, "second shot");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_zero();
    t_modes();
    t_single();
    end_sim();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
endmodule // ptb_time_base_tb_top
`default_nettype wire
